// ===== verilog/gpcd_pkg.sv
// constants, field layout and carrier types of the port c / port d block
// assumes one 25 MHz core clock and a plain address/strobe register port
package gpcd_pkg;
   localparam logic [2:0] GPCD_ADDR_C_PINS  = 3'h0;
   localparam logic [2:0] GPCD_ADDR_C_LATCH = 3'h1;
   localparam logic [2:0] GPCD_ADDR_C_DIR   = 3'h2;
   localparam logic [2:0] GPCD_ADDR_D_PINS  = 3'h3;
   localparam logic [2:0] GPCD_ADDR_D_LATCH = 3'h4;
   localparam logic [2:0] GPCD_ADDR_D_DIR   = 3'h5;
   localparam logic [2:0] GPCD_ADDR_E_CTRL  = 3'h6;

   localparam logic [7:0] GPCD_DIR_RESET    = 8'hFF;
   localparam logic [7:0] GPCD_E_CTRL_RESET = 8'h07;
   localparam logic [7:0] GPCD_C_GPIO_MASK  = 8'hF9;
   localparam logic [7:0] GPCD_C_RSVD_MASK  = 8'h06;
   localparam logic [7:0] GPCD_E_WRITE_MASK = 8'h37;

   localparam int GPCD_E_IBF  = 7;
   localparam int GPCD_E_OBF  = 6;
   localparam int GPCD_E_INPUT_OVERFLOW_FLAG = 5;
   localparam int GPCD_E_MODE = 4;

   localparam int GPCD_PWM_LO = 1;
   localparam int GPCD_PWM_HI = 2;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } gpcd_req_t;

   typedef struct packed {
      logic [7:0] in;
      logic [7:0] out;
      logic [7:0] oe_b;
   } gpcd_pin_t;

   typedef struct packed {
      logic [7:0] force_en;
      logic [7:0] force_out;
      logic [7:0] out_val;
   } gpcd_ovr_t;

   typedef struct packed {
      logic cs_b;
      logic rd_b;
      logic wr_b;
   } gpcd_psp_t;
endpackage

// ===== verilog/gpcd_ports.sv
// port c and port d pins with direction, latch, override and parallel slave port
// assumes pins and parallel strobes already synchronous to sys_clk
module gpcd_ports (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   // register port
   input  wire gpcd_pkg::gpcd_req_t req,
   output logic [7:0]             rdata,
   // port c pins and peripheral overrides
   input  wire logic [7:0]        c_in,
   output logic [7:0]             c_out,
   output logic [7:0]             c_oe_b,
   input  wire gpcd_pkg::gpcd_ovr_t c_ovr,
   input  wire logic [1:0]        pwm_val,
   output logic [1:0]             pwm_out,
   // port d pins
   input  wire logic [7:0]        d_in,
   output logic [7:0]             d_out,
   output logic [7:0]             d_oe_b,
   // parallel slave strobes from port e pins
   input  wire gpcd_pkg::gpcd_psp_t parallel_slave_port,
   output logic [2:0]             e_dir
);
   logic [7:0] c_latch_reg, c_latch_next;
   logic [7:0] c_dir_reg, c_dir_next;
   logic [7:0] d_latch_reg, d_latch_next;
   logic [7:0] d_dir_reg, d_dir_next;
   logic [7:0] e_ctrl_reg, e_ctrl_next;
   logic [7:0] psp_in_reg, psp_in_next;
   logic       wr_seen_reg, rd_seen_reg;
   logic [7:0] rdata_reg, rdata_next;
   logic [1:0] pwm_reg;

   // control register layout beyond the flag bits named in the package
   localparam int E_UNUSED_BIT = 3;
   localparam int E_DIR_HI     = 2;

   function automatic logic hit(input logic [2:0] a, input logic [2:0] want, input logic s);
      hit = s && (a == want);
   endfunction

   wire psp_mode  = e_ctrl_reg[gpcd_pkg::GPCD_E_MODE];
   // select and strobe low together; only the first cycle counts as the event
   wire psp_wr_lv = psp_mode && !parallel_slave_port.cs_b && !parallel_slave_port.wr_b;
   wire psp_rd_lv = psp_mode && !parallel_slave_port.cs_b && !parallel_slave_port.rd_b;
   wire psp_wr    = psp_wr_lv && !wr_seen_reg;
   wire psp_rd    = psp_rd_lv && !rd_seen_reg;

   wire w_c_pins  = hit(req.addr, gpcd_pkg::GPCD_ADDR_C_PINS,  req.wr);
   wire w_c_latch = hit(req.addr, gpcd_pkg::GPCD_ADDR_C_LATCH, req.wr);
   wire w_c_dir   = hit(req.addr, gpcd_pkg::GPCD_ADDR_C_DIR,   req.wr);
   wire w_d_pins  = hit(req.addr, gpcd_pkg::GPCD_ADDR_D_PINS,  req.wr);
   wire w_d_latch = hit(req.addr, gpcd_pkg::GPCD_ADDR_D_LATCH, req.wr);
   wire w_d_dir   = hit(req.addr, gpcd_pkg::GPCD_ADDR_D_DIR,   req.wr);
   wire w_e_ctrl  = hit(req.addr, gpcd_pkg::GPCD_ADDR_E_CTRL,  req.wr);
   // in parallel mode a cpu read of port d takes the received word
   wire r_d_pins  = hit(req.addr, gpcd_pkg::GPCD_ADDR_D_PINS,  req.rd) && psp_mode;

   // reserved bits 1,2 are stored as written; they never reach a pin
   assign c_latch_next = (w_c_pins || w_c_latch) ? req.wdata : c_latch_reg;
   assign c_dir_next   = w_c_dir ? req.wdata : c_dir_reg;
   assign d_latch_next = (w_d_pins || w_d_latch) ? req.wdata : d_latch_reg;
   assign d_dir_next   = w_d_dir ? req.wdata : d_dir_reg;
   assign psp_in_next  = psp_wr ? d_in : psp_in_reg;

   // flags: hardware set wins over software clear
   logic [7:0] e_sw;
   assign e_sw = w_e_ctrl ? ((req.wdata & gpcd_pkg::GPCD_E_WRITE_MASK)
                             | (e_ctrl_reg & ~gpcd_pkg::GPCD_E_WRITE_MASK))
                          : e_ctrl_reg;
   always_comb begin
      e_ctrl_next = e_sw;
      e_ctrl_next[E_UNUSED_BIT] = 1'b0;
      if (psp_wr) begin
         e_ctrl_next[gpcd_pkg::GPCD_E_IBF] = 1'b1;
         if (e_ctrl_reg[gpcd_pkg::GPCD_E_IBF]) begin
            e_ctrl_next[gpcd_pkg::GPCD_E_INPUT_OVERFLOW_FLAG] = 1'b1;
         end
      end else if (r_d_pins) begin
         e_ctrl_next[gpcd_pkg::GPCD_E_IBF] = 1'b0;
      end
      if (psp_mode && (w_d_pins || w_d_latch)) begin
         e_ctrl_next[gpcd_pkg::GPCD_E_OBF] = 1'b1;
      end else if (psp_rd) begin
         e_ctrl_next[gpcd_pkg::GPCD_E_OBF] = 1'b0;
      end
   end

   // read mux: pins for port regs (port d gives the received word in parallel mode), latches and directions as stored
   always_comb begin
      case (req.addr)
         gpcd_pkg::GPCD_ADDR_C_PINS:  rdata_next = c_in;
         gpcd_pkg::GPCD_ADDR_C_LATCH: rdata_next = c_latch_reg;
         gpcd_pkg::GPCD_ADDR_C_DIR:   rdata_next = c_dir_reg;
         gpcd_pkg::GPCD_ADDR_D_PINS:  rdata_next = psp_mode ? psp_in_reg : d_in;
         gpcd_pkg::GPCD_ADDR_D_LATCH: rdata_next = d_latch_reg;
         gpcd_pkg::GPCD_ADDR_D_DIR:   rdata_next = d_dir_reg;
         gpcd_pkg::GPCD_ADDR_E_CTRL:  rdata_next = e_ctrl_reg;
         default:                     rdata_next = 8'h00;
      endcase
      if (!req.rd) begin
         rdata_next = rdata_reg;
      end
   end

   // latches keep their value over reset: no reset term on purpose
   always_ff @(posedge sys_clk) begin
      c_latch_reg <= c_latch_next;
      d_latch_reg <= d_latch_next;
      psp_in_reg  <= psp_in_next;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         c_dir_reg   <= gpcd_pkg::GPCD_DIR_RESET;
         d_dir_reg   <= gpcd_pkg::GPCD_DIR_RESET;
         e_ctrl_reg  <= gpcd_pkg::GPCD_E_CTRL_RESET;
         wr_seen_reg <= 1'b0;
         rd_seen_reg <= 1'b0;
         rdata_reg   <= 8'h00;
         pwm_reg     <= 2'h0;
      end else begin
         c_dir_reg   <= c_dir_next;
         d_dir_reg   <= d_dir_next;
         e_ctrl_reg  <= e_ctrl_next;
         wr_seen_reg <= psp_wr_lv;
         rd_seen_reg <= psp_rd_lv;
         rdata_reg   <= rdata_next;
         pwm_reg     <= pwm_val;
      end
   end

   // port c: override forces direction and value per pin, register untouched
   logic [7:0] c_dir_eff, c_val_eff;
   assign c_dir_eff = (c_ovr.force_en & ~c_ovr.force_out) | (~c_ovr.force_en & c_dir_reg);
   assign c_val_eff = (c_ovr.force_en & c_ovr.out_val) | (~c_ovr.force_en & c_latch_reg);
   // reserved positions kept high-impedance here, pwm has its own outputs
   assign c_oe_b  = c_dir_eff | gpcd_pkg::GPCD_C_RSVD_MASK;
   assign c_out   = c_val_eff & gpcd_pkg::GPCD_C_GPIO_MASK;
   assign pwm_out = pwm_reg;

   // port d: in parallel mode drive only during an external read
   wire d_drive_psp = psp_rd_lv;
   assign d_oe_b = psp_mode ? {8{!d_drive_psp}} : d_dir_reg;
   assign d_out  = d_latch_reg;

   assign e_dir  = e_ctrl_reg[E_DIR_HI:0];
   assign rdata  = rdata_reg;
endmodule

// ===== sim/gpcd_ports_sva.sv
// assertions on the pins and register port of gpcd_ports
// sees only the top ports; bound into every gpcd_ports instance
module gpcd_ports_sva (
   // clock and reset
   input wire logic                sys_clk,
   input wire logic                rst_b,
   // register port and pins
   input wire gpcd_pkg::gpcd_req_t req,
   input wire logic [7:0]          c_out,
   input wire logic [7:0]          c_oe_b,
   input wire gpcd_pkg::gpcd_ovr_t c_ovr,
   input wire logic [1:0]          pwm_val,
   input wire logic [1:0]          pwm_out,
   input wire logic [7:0]          d_out,
   input wire logic [7:0]          d_oe_b,
   input wire logic [2:0]          e_dir
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_wr(logic [2:0] a);
      req.wr && req.addr == a;
   endsequence
   a_dir_reset: assert property (disable iff (1'b0)
      !rst_b |=> d_oe_b == 8'hFF && e_dir == 3'h7) else $error("direction reset wrong");
   a_pwm_pins_fixed: assert property (c_oe_b[2:1] == 2'b11 && c_out[2:1] == 2'b00)
      else $error("reserved port c pins driven");
   a_pwm_follow: assert property (1'b1 |=> pwm_out == $past(pwm_val))
      else $error("pwm output does not follow");
   a_c_latch_drive: assert property (s_wr(gpcd_pkg::GPCD_ADDR_C_LATCH) |=>
      c_ovr.force_en != 8'h00 || c_out == ($past(req.wdata) & 8'hF9)) else $error("c latch");
   a_c_dir_float: assert property (s_wr(gpcd_pkg::GPCD_ADDR_C_DIR) |=>
      c_ovr.force_en != 8'h00 || c_oe_b == ($past(req.wdata) | 8'h06)) else $error("c dir");
   a_ovr_wins: assert property ((c_oe_b & c_ovr.force_en & 8'hF9) ==
      (~c_ovr.force_out & c_ovr.force_en & 8'hF9)) else $error("override ignored");
   a_d_latch_out: assert property (s_wr(gpcd_pkg::GPCD_ADDR_D_LATCH) |=>
      d_out == $past(req.wdata)) else $error("d latch not driven");
   a_e_dir_write: assert property (s_wr(gpcd_pkg::GPCD_ADDR_E_CTRL) |=>
      e_dir == $past(req.wdata[2:0])) else $error("port e direction not written");
endmodule
bind gpcd_ports gpcd_ports_sva chk (.sys_clk(sys_clk), .rst_b(rst_b), .req(req),
   .c_out(c_out), .c_oe_b(c_oe_b), .c_ovr(c_ovr), .pwm_val(pwm_val), .pwm_out(pwm_out),
   .d_out(d_out), .d_oe_b(d_oe_b), .e_dir(e_dir));

// ===== sim/gpcd_pin_model.sv
// outside world on the port c and port d pins
// a floated pin shows what the outside parts drive, c_ext or d_ext
module gpcd_pin_model (
   // block side
   input wire logic [7:0] c_out,
   input wire logic [7:0] c_oe_b,
   input wire logic [7:0] d_out,
   input wire logic [7:0] d_oe_b,
   // outside drive and resolved levels
   input wire logic [7:0] c_ext,
   input wire logic [7:0] d_ext,
   output logic [7:0]     c_in,
   output logic [7:0]     d_in
);
   assign c_in = (c_out & ~c_oe_b) | (c_ext & c_oe_b);
   assign d_in = (d_out & ~d_oe_b) | (d_ext & d_oe_b);
endmodule

// ===== sim/gpcd_ports_bench.sv
// self-checking bench for gpcd_ports: register tasks and pin scenarios
// assumes the pin model resolves both ports from drive and outside levels
module gpcd_ports_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                sys_clk, rst_b;
   gpcd_pkg::gpcd_req_t req;
   gpcd_pkg::gpcd_ovr_t c_ovr;
   gpcd_pkg::gpcd_psp_t parallel_slave_port;
   logic [7:0]          rdata, c_in, c_out, c_oe_b, d_in, d_out, d_oe_b, c_ext, d_ext;
   logic [1:0]          pwm_val, pwm_out;
   logic [2:0]          e_dir;
   int                  bad_count = 0;
   int                  samples_checked = 0;
   gpcd_ports dut (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .rdata(rdata), .c_in(c_in),
      .c_out(c_out), .c_oe_b(c_oe_b), .c_ovr(c_ovr), .pwm_val(pwm_val), .pwm_out(pwm_out),
      .d_in(d_in), .d_out(d_out), .d_oe_b(d_oe_b), .parallel_slave_port(parallel_slave_port), .e_dir(e_dir));
   gpcd_pin_model pins (.c_out(c_out), .c_oe_b(c_oe_b), .d_out(d_out), .d_oe_b(d_oe_b),
      .c_ext(c_ext), .d_ext(d_ext), .c_in(c_in), .d_in(d_in));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   // trailing edge keeps back-to-back calls from assigning a strobe twice at once
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 chk(nm, rdata, exp);
      @(posedge sys_clk);
   endtask
   // external processor: select and strobe low together for one cycle
   task automatic pw(input logic [2:0] s);
      parallel_slave_port <= s;
      @(posedge sys_clk);
      parallel_slave_port <= 3'b111;
      @(posedge sys_clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (400) @(posedge sys_clk);
      bad_count++;
      wrap_up;
   end
   initial begin
      rst_b = 1'b0;
      req = '0;
      c_ovr = '0;
      parallel_slave_port = 3'b111;
      pwm_val = 2'b10;
      c_ext = 8'hAA;
      d_ext = 8'h5A;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(gpcd_pkg::GPCD_ADDR_C_DIR, 8'hFF, "c dir");
      rd(gpcd_pkg::GPCD_ADDR_D_DIR, 8'hFF, "d dir");
      rd(gpcd_pkg::GPCD_ADDR_E_CTRL, 8'h07, "e ctrl");
      #1 chk("pwm", {6'h00, pwm_out}, 8'h02);
      wr(gpcd_pkg::GPCD_ADDR_C_LATCH, 8'h55);
      rd(gpcd_pkg::GPCD_ADDR_C_LATCH, 8'h55, "c latch");
      rd(gpcd_pkg::GPCD_ADDR_C_PINS, 8'hAA, "c pins in");
      wr(gpcd_pkg::GPCD_ADDR_C_DIR, 8'h00);
      rd(gpcd_pkg::GPCD_ADDR_C_PINS, 8'h53, "c pins out");
      chk("c_out", c_out, 8'h51);
      c_ovr <= '{8'h81, 8'h80, 8'hFF};
      @(posedge sys_clk);
      #1 chk("c_oe_b", c_oe_b, 8'h07);
      rd(gpcd_pkg::GPCD_ADDR_C_DIR, 8'h00, "c dir kept");
      c_ovr <= '0;
      wr(gpcd_pkg::GPCD_ADDR_D_LATCH, 8'h3C);
      wr(gpcd_pkg::GPCD_ADDR_D_DIR, 8'h0F);
      rd(gpcd_pkg::GPCD_ADDR_D_PINS, 8'h3A, "d pins");
      wr(gpcd_pkg::GPCD_ADDR_E_CTRL, 8'h17);
      pw(3'b010);
      pw(3'b010);
      rd(gpcd_pkg::GPCD_ADDR_E_CTRL, 8'hB7, "e ctrl ovf");
      rd(gpcd_pkg::GPCD_ADDR_D_PINS, 8'h5A, "slave word");
      rd(gpcd_pkg::GPCD_ADDR_E_CTRL, 8'h37, "e ctrl read");
      wr(gpcd_pkg::GPCD_ADDR_D_LATCH, 8'h3C);
      rd(gpcd_pkg::GPCD_ADDR_E_CTRL, 8'h77, "e ctrl obf set");
      parallel_slave_port <= 3'b001;
      @(posedge sys_clk);
      #1 chk("d_oe_b", d_oe_b, 8'h00);
      chk("d_out", d_out, 8'h3C);
      parallel_slave_port <= 3'b111;
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00, "unmapped");
      chk("d_oe_b idle", d_oe_b, 8'hFF);
      rd(gpcd_pkg::GPCD_ADDR_E_CTRL, 8'h37, "e ctrl obf clear");
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(gpcd_pkg::GPCD_ADDR_D_LATCH, 8'h3C, "d latch kept");
      rd(gpcd_pkg::GPCD_ADDR_D_DIR, 8'hFF, "d dir reset");
      wrap_up;
   end
endmodule
